// *** bench/flash_security_and_clock_divider_test.sv ***
// flash_security_and_clock_divider_test: directed register/memory tests
// assumes: fsc_top with bound monitor, memory model on the raw read path
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    error_cnt++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module flash_security_and_clock_divider_test;
    import fsc_pkg::*;
    logic clk, rst_b = 0, rd = 0, wr = 0, rdbg = 0, mreq = 0, mwr = 0;
    logic mfs = 0, mfd = 0, bok = 0, bdbg = 0, pin = 1, mts = 1;
    logic grant, wout, sec, dbgen, bkgd, pgm, kprot, tp, aerr;
    logic [3:0] ra = 0;
    logic [7:0] rwd = 0, opts = 0, mwd = 0, rdat, mrd, mri, d;
    logic [15:0] ma = 0;
    logic [63:0] key = 64'h0123_4567_89AB_CDEF;
    int error_cnt = 0, samples_checked = 0, n;
    fsc_top dut (.CLOCK(clk), .RST_B(rst_b), .REG_ADDR(ra),
        .REG_WDATA(rwd), .REG_WR(wr), .REG_RD(rd), .REG_FROM_DEBUG(rdbg),
        .REG_RDATA(rdat), .NV_OPTIONS(opts), .NV_PROTECT(8'hFF),
        .NV_KEY(key), .BKGD_PIN(pin), .MEM_REQ(mreq), .MEM_WR(mwr),
        .MEM_ADDR(ma), .MEM_WDATA(mwd), .MEM_TO_SECURE(mts),
        .MEM_FROM_SECURE(mfs), .MEM_FROM_DEBUG(mfd), .MEM_RDATA_IN(mri),
        .MEM_GRANT(grant), .MEM_WR_OUT(wout), .MEM_RDATA(mrd),
        .BLANK_OK(bok), .BLANK_FROM_DEBUG(bdbg), .SECURE(sec),
        .DEBUG_EN_ALLOW(dbgen), .BKGD_ENTRY(bkgd), .PGM_ENABLE(pgm),
        .KEY_PROTECTED(kprot), .TIMING_PULSE(tp), .ACCESS_ERROR(aerr));
    fsc_core_model u_mem (.clk(clk), .req(mreq), .addr(ma), .rdata(mri));
    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task automatic rst(input logic [7:0] o, input logic p);
        rst_b <= 1'b0;
        opts <= o;
        pin <= p;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask : rst
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v,
                          input logic g);
        @(posedge clk);
        ra <= a;
        rwd <= v;
        rdbg <= g;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdat;
    endtask : reg_rd
    task automatic mem(input logic w, input logic [15:0] a,
                       input logic [7:0] v, input logic s, input logic g);
        @(posedge clk);
        mreq <= 1'b1;
        mwr <= w;
        ma <= a;
        mwd <= v;
        mfs <= s;
        mfd <= g;
        @(posedge clk);
        mreq <= 1'b0;
        #1;
    endtask : mem
    task automatic enter_key(input logic g, input logic [7:0] f);
        reg_wr(ADDR_CONFIG, 8'h20, 1'b0);
        for (int i = 0; i < KEY_BYTES; i++)
        begin
            mem(1'b1, KEY_BASE + 16'(i), key[8*i +: 8] ^ (i == 3 ? f : 8'h00),
                1'b1, g);
        end
        reg_wr(ADDR_CONFIG, 8'h00, 1'b0);
        repeat (3) @(posedge clk);
        #1;
    endtask : enter_key
    task automatic per(output int c);
        c = 0;
        while (tp !== 1'b1 && c < 200)
        begin
            @(posedge clk);
            #1;
            c++;
        end
        if (c >= 200)
        begin
            error_cnt++;
            finish_test();
        end
        c = 0;
        do
        begin
            @(posedge clk);
            #1;
            c++;
        end while (tp !== 1'b1 && c < 200);
    endtask : per
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial
    begin
        #200000;
        error_cnt++;
        finish_test();
    end
    initial
    begin
        rst(8'h83, 1'b1);
        `CHK("secure", 1'b1, sec)
        `CHK("bkgd", 1'b0, bkgd)
        `CHK("dbg_en", 1'b0, dbgen)
        reg_rd(ADDR_OPTIONS, d);
        `CHK("options", 8'h83, d)
        mem(1'b0, 16'h8012, 8'h00, 1'b0, 1'b0);
        `CHK("unsec_rd", 8'h00, mrd)
        mem(1'b0, 16'h8012, 8'h00, 1'b1, 1'b1);
        `CHK("dbg_rd", 1'b0, grant)
        mem(1'b0, 16'h8012, 8'h00, 1'b1, 1'b0);
        `CHK("sec_rd", 8'h48, mrd)
        mem(1'b1, 16'h8012, 8'h11, 1'b1, 1'b0);
        `CHK("early_err", 1'b1, aerr)
        `CHK("sec_wr", 1'b1, wout)
        `CHK("pgm_off", 1'b0, pgm)
        reg_wr(ADDR_CLKDIV, 8'h41, 1'b0);
        reg_wr(ADDR_CLKDIV, 8'h05, 1'b0);
        reg_rd(ADDR_CLKDIV, d);
        `CHK("clkdiv", 8'hC1, d)
        `CHK("pgm_on", 1'b1, pgm)
        mem(1'b1, 16'h8012, 8'h11, 1'b0, 1'b0);
        `CHK("blk_wr", 1'b0, wout)
        reg_wr(ADDR_ERRCLR, 8'h02, 1'b0);
        reg_rd(ADDR_STATUS, d);
        `CHK("status", 8'h05, d)
        `CHK("err_clr", 1'b0, aerr)
        per(n);
        `CHK("period8", 16, n)
        $display("test divider done");
        reg_wr(ADDR_PROTECT, 8'h00, 1'b0);
        reg_rd(ADDR_PROTECT, d);
        `CHK("prot_app", 8'hFF, d)
        reg_wr(ADDR_PROTECT, 8'hDE, 1'b1);
        reg_rd(ADDR_PROTECT, d);
        `CHK("prot_dbg", 8'hDE, d)
        `CHK("key_prot", 1'b1, kprot)
        reg_wr(ADDR_CONFIG, 8'hFF, 1'b0);
        reg_rd(ADDR_CONFIG, d);
        `CHK("config", 8'hE0, d)
        reg_rd(4'hF, d);
        `CHK("unmapped", 8'h00, d)
        $display("test registers done");
        enter_key(1'b0, 8'h01);
        `CHK("bad_key", 1'b1, sec)
        enter_key(1'b1, 8'h00);
        `CHK("dbg_key", 1'b1, sec)
        enter_key(1'b0, 8'h00);
        `CHK("good_key", 1'b0, sec)
        `CHK("dbg_en_on", 1'b1, dbgen)
        mem(1'b0, 16'h8012, 8'h00, 1'b0, 1'b1);
        `CHK("open_rd", 8'h48, mrd)
        $display("test key done");
        rst(8'h03, 1'b0);
        `CHK("bkgd_low", 1'b1, bkgd)
        reg_wr(ADDR_CLKDIV, 8'h03, 1'b0);
        per(n);
        `CHK("period", 4, n)
        enter_key(1'b0, 8'h00);
        `CHK("backdoor_key_enable_off", 1'b1, sec)
        @(posedge clk);
        bok <= 1'b1;
        bdbg <= 1'b1;
        @(posedge clk);
        bok <= 1'b0;
        bdbg <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("blank", 1'b0, sec)
        for (int c = 0; c < 4; c++)
        begin
            rst({6'h00, 2'(c)}, 1'b1);
            `CHK("sec_code", (c != 2), sec)
        end
        $display("test reset done");
        finish_test();
    end
endmodule : flash_security_and_clock_divider_test

// *** bench/fsc_core_model.sv ***
// fsc_core_model: address-derived data model (addr[7:0] ^ 5A) answering raw reads for the gate
// assumes: answer in the request cycle, garbage otherwise
`timescale 1ns/1ps
module fsc_core_model
(
    input wire logic clk,
    input wire logic req,
    input wire logic [15:0] addr,
    output logic [7:0] rdata
);
    logic [7:0] last_r = 8'h00;
    // idle data toggles every cycle so stale values never match
    always_comb
    begin
        rdata = req ? (addr[7:0] ^ 8'h5A) : ~last_r;
    end
    always_ff @(posedge clk)
    begin
        last_r <= rdata;
    end
endmodule : fsc_core_model

// *** bench/fsc_top_monitor.sv ***
// fsc_top_monitor: port-level checks on the security gate and divider
// assumes: bound to fsc_top, one clock domain, reset active low
`timescale 1ns/1ps
module fsc_monitor
    import fsc_pkg::*;
#(
    parameter int DIV_W = 6
)
(
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic [3:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic MEM_REQ,
    input wire logic MEM_WR,
    input wire logic MEM_TO_SECURE,
    input wire logic MEM_FROM_SECURE,
    input wire logic MEM_FROM_DEBUG,
    input wire logic [7:0] MEM_RDATA_IN,
    input wire logic MEM_GRANT,
    input wire logic [7:0] MEM_RDATA,
    input wire logic BLANK_OK,
    input wire logic BLANK_FROM_DEBUG,
    input wire logic SECURE,
    input wire logic DEBUG_EN_ALLOW,
    input wire logic PGM_ENABLE,
    input wire logic TIMING_PULSE,
    input wire logic ACCESS_ERROR
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);
    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_BLOCK_RD: assert property (
        MEM_REQ && !MEM_WR && MEM_TO_SECURE && SECURE &&
        (!MEM_FROM_SECURE || MEM_FROM_DEBUG)
        |=> !MEM_GRANT && MEM_RDATA == 8'h00)
        else $error("blocked read leaked");
    AST_SEC_PASS: assert property (
        MEM_REQ && !MEM_WR && MEM_FROM_SECURE && !MEM_FROM_DEBUG
        |=> MEM_GRANT && MEM_RDATA == $past(MEM_RDATA_IN))
        else $error("secure read not passed");
    AST_DBG_OFF: assert property (
        SECURE && $past(SECURE) |-> !DEBUG_EN_ALLOW)
        else $error("debug allowed while secure");
    AST_BLANK: assert property (
        BLANK_OK && BLANK_FROM_DEBUG |-> ##2 !SECURE)
        else $error("blank check did not unlock");
    AST_STAY_OPEN: assert property (
        !SECURE |=> !SECURE)
        else $error("security came back before reset");
    AST_LOAD: assert property (
        REG_WR && REG_ADDR == ADDR_CLKDIV |-> ##2 PGM_ENABLE)
        else $error("divider write did not set loaded");
    AST_FLAG_RD: assert property (
        REG_RD && REG_ADDR == ADDR_CLKDIV
        |=> REG_RDATA[CDIV_LOADED_BIT] == PGM_ENABLE)
        else $error("divider flag read wrong");
    AST_CFG_LOW: assert property (
        REG_RD && REG_ADDR == ADDR_CONFIG |=> REG_RDATA[4:0] == 5'h00)
        else $error("config low bits not zero");
    AST_EARLY_ERR: assert property (
        !PGM_ENABLE && MEM_REQ && MEM_WR && MEM_TO_SECURE
        |=> ACCESS_ERROR)
        else $error("early write not flagged");
    AST_PULSE_GATE: assert property (
        TIMING_PULSE |-> PGM_ENABLE ##1 !TIMING_PULSE)
        else $error("timing pulse without divider");
    COV_UNLOCK: cover property (SECURE ##1 !SECURE);
    COV_BLOCK: cover property (MEM_REQ && SECURE && !MEM_FROM_SECURE);
    COV_PULSE: cover property (TIMING_PULSE);
endmodule : fsc_monitor

bind fsc_top fsc_monitor #(.DIV_W(DIV_W)) u_mon (
    .CLOCK(CLOCK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MEM_REQ(MEM_REQ),
    .MEM_WR(MEM_WR), .MEM_TO_SECURE(MEM_TO_SECURE),
    .MEM_FROM_SECURE(MEM_FROM_SECURE), .MEM_FROM_DEBUG(MEM_FROM_DEBUG),
    .MEM_RDATA_IN(MEM_RDATA_IN), .MEM_GRANT(MEM_GRANT),
    .MEM_RDATA(MEM_RDATA), .BLANK_OK(BLANK_OK),
    .BLANK_FROM_DEBUG(BLANK_FROM_DEBUG), .SECURE(SECURE),
    .DEBUG_EN_ALLOW(DEBUG_EN_ALLOW), .PGM_ENABLE(PGM_ENABLE),
    .TIMING_PULSE(TIMING_PULSE), .ACCESS_ERROR(ACCESS_ERROR));

// *** logic/fsc_pkg.sv ***
// fsc_pkg: register map, field layout, reset values and timing constants
// assumes: one bus clock domain, byte-wide registers on a plain port
package fsc_pkg;

    // ------------------------------------------------------------------
    // register map (chosen offsets)
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CLKDIV = 4'h0;
    localparam logic [3:0] ADDR_OPTIONS = 4'h1;
    localparam logic [3:0] ADDR_CONFIG = 4'h2;
    localparam logic [3:0] ADDR_PROTECT = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_ERRCLR = 4'h5;
    localparam logic [3:0] ADDR_KEYCAP = 4'h6;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int CDIV_LOADED_BIT = 7;
    localparam int CDIV_PRESCALE_BIT = 6;
    localparam int OPT_BACKDOOR_KEY_ENABLE_BIT = 7;
    localparam int CFG_KEY_ACCESS_ENABLE_BIT = 5;
    localparam logic [7:0] CFG_WRITE_MASK = 8'hE0;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam int STAT_SECURE_BIT = 0;
    localparam int STAT_ACCERR_BIT = 1;
    localparam int STAT_PGM_EN_BIT = 2;
    localparam int STAT_DBG_EN_BIT = 3;
    localparam int STAT_BKGD_BIT = 4;

    // ------------------------------------------------------------------
    // reset values and sizes
    // ------------------------------------------------------------------
    localparam logic [7:0] CLKDIV_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [7:0] PROTECT_RST = 8'hFF;
    localparam int KEY_BYTES = 8;
    localparam logic [15:0] KEY_BASE = 16'hFFB0;
    localparam logic [15:0] VECTOR_BLOCK_BASE = 16'hFE00;
    localparam logic [2:0] PRESCALE_LAST = 3'h7;

endpackage : fsc_pkg

// *** logic/fsc_top.sv ***
// fsc_top: memory security gate, backdoor key unlock, blank-check unlock,
// protection register and write-once timing clock divider
// assumes: memory requests come from the core or debug controller on
// CLOCK; strap and background pin are asynchronous and get synchronised
`timescale 1ns/1ps

module fsc_top
    import fsc_pkg::*;
#(
    parameter int DIV_W = 6
)
(
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic REG_FROM_DEBUG,
    output logic [7:0] REG_RDATA,
    input wire logic [7:0] NV_OPTIONS,
    input wire logic [7:0] NV_PROTECT,
    input wire logic [63:0] NV_KEY,
    input wire logic BKGD_PIN,
    input wire logic MEM_REQ,
    input wire logic MEM_WR,
    input wire logic [15:0] MEM_ADDR,
    input wire logic [7:0] MEM_WDATA,
    input wire logic MEM_TO_SECURE,
    input wire logic MEM_FROM_SECURE,
    input wire logic MEM_FROM_DEBUG,
    input wire logic [7:0] MEM_RDATA_IN,
    output logic MEM_GRANT,
    output logic MEM_WR_OUT,
    output logic [7:0] MEM_RDATA,
    input wire logic BLANK_OK,
    input wire logic BLANK_FROM_DEBUG,
    output logic SECURE,
    output logic DEBUG_EN_ALLOW,
    output logic BKGD_ENTRY,
    output logic PGM_ENABLE,
    output logic KEY_PROTECTED,
    output logic TIMING_PULSE,
    output logic ACCESS_ERROR
);
    import fsc_pkg::*;

    // ------------------------------------------------------------------
    // synchronisers and reset capture
    // ------------------------------------------------------------------
    logic bkgd_s1_r, bkgd_s2_r;
    logic loaded_r;
    logic [7:0] options_r;
    logic [7:0] protect_r;
    logic bkgd_low_r;

    // runs through reset: the strap level must sit in both flops
    // by the first edge after release, when it is captured
    always_ff @(posedge CLOCK)
    begin
        bkgd_s1_r <= BKGD_PIN;
        bkgd_s2_r <= bkgd_s1_r;
    end

    // option and protection bytes captured at first edge after release
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            loaded_r <= 1'b0;
            options_r <= 8'h00;
            protect_r <= PROTECT_RST;
            bkgd_low_r <= 1'b0;
        end
        else if (!loaded_r)
        begin
            loaded_r <= 1'b1;
            options_r <= NV_OPTIONS & 8'hC3;
            protect_r <= NV_PROTECT;
            bkgd_low_r <= ~bkgd_s2_r;
        end
        else if (REG_WR && REG_FROM_DEBUG && REG_ADDR == ADDR_PROTECT)
        begin
            protect_r <= REG_WDATA;
        end
    end

    // ------------------------------------------------------------------
    // security state
    // ------------------------------------------------------------------
    logic unlock_r;
    logic secure_nxt;
    logic key_unlock;

    assign secure_nxt = loaded_r && !unlock_r
        && options_r[1:0] != SEC_UNSECURED;

    // ------------------------------------------------------------------
    // configuration and key capture
    // ------------------------------------------------------------------
    logic [7:0] config_r;
    logic [63:0] key_buf_r;
    logic [7:0] key_seen_r;
    logic key_wr;
    logic [2:0] key_idx;

    assign key_idx = MEM_ADDR[2:0];
    assign key_wr = MEM_REQ && MEM_WR && config_r[CFG_KEY_ACCESS_ENABLE_BIT]
        && MEM_FROM_SECURE && !MEM_FROM_DEBUG
        && MEM_ADDR[15:3] == KEY_BASE[15:3];

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            config_r <= CONFIG_RST;
        end
        else if (REG_WR && REG_ADDR == ADDR_CONFIG)
        begin
            config_r <= REG_WDATA & CFG_WRITE_MASK;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            key_buf_r <= 64'h0;
            key_seen_r <= 8'h00;
        end
        else if (key_wr)
        begin
            key_buf_r[key_idx*8 +: 8] <= MEM_WDATA;
            key_seen_r[key_idx] <= 1'b1;
        end
        else if (REG_WR && REG_ADDR == ADDR_CONFIG
                 && REG_WDATA[CFG_KEY_ACCESS_ENABLE_BIT])
        begin
            key_seen_r <= 8'h00;
        end
    end

    assign key_unlock = REG_WR && REG_ADDR == ADDR_CONFIG
        && config_r[CFG_KEY_ACCESS_ENABLE_BIT] && !REG_WDATA[CFG_KEY_ACCESS_ENABLE_BIT]
        && options_r[OPT_BACKDOOR_KEY_ENABLE_BIT] && key_seen_r == 8'hFF
        && key_buf_r == NV_KEY;

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            unlock_r <= 1'b0;
        end
        else if (key_unlock)
        begin
            unlock_r <= 1'b1;
        end
        else if (BLANK_OK && BLANK_FROM_DEBUG)
        begin
            unlock_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // clock divider register
    // ------------------------------------------------------------------
    logic [7:0] clkdiv_r;

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            clkdiv_r <= CLKDIV_RST;
        end
        else if (REG_WR && REG_ADDR == ADDR_CLKDIV
                 && !clkdiv_r[CDIV_LOADED_BIT])
        begin
            clkdiv_r <= {1'b1, REG_WDATA[6:0]};
        end
    end

    // ------------------------------------------------------------------
    // timing clock generation
    // ------------------------------------------------------------------
    logic [2:0] pre_cnt_r;
    logic [DIV_W-1:0] div_cnt_r;
    logic pre_tick;
    logic div_tick;

    assign pre_tick = !clkdiv_r[CDIV_PRESCALE_BIT]
        || pre_cnt_r == PRESCALE_LAST;
    assign div_tick = pre_tick && div_cnt_r == clkdiv_r[DIV_W-1:0];

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            pre_cnt_r <= 3'h0;
        end
        else if (!clkdiv_r[CDIV_LOADED_BIT])
        begin
            pre_cnt_r <= 3'h0;
        end
        else
        begin
            pre_cnt_r <= pre_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            div_cnt_r <= '0;
        end
        else if (!clkdiv_r[CDIV_LOADED_BIT] || div_tick)
        begin
            div_cnt_r <= '0;
        end
        else if (pre_tick)
        begin
            div_cnt_r <= div_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            TIMING_PULSE <= 1'b0;
        end
        else
        begin
            TIMING_PULSE <= clkdiv_r[CDIV_LOADED_BIT] && div_tick;
        end
    end

    // ------------------------------------------------------------------
    // access error flag (set wins over clear)
    // ------------------------------------------------------------------
    logic err_set;

    assign err_set = MEM_REQ && MEM_WR && MEM_TO_SECURE && !key_wr
        && !clkdiv_r[CDIV_LOADED_BIT];

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ACCESS_ERROR <= 1'b0;
        end
        else if (err_set)
        begin
            ACCESS_ERROR <= 1'b1;
        end
        else if (REG_WR && REG_ADDR == ADDR_ERRCLR
                 && REG_WDATA[STAT_ACCERR_BIT])
        begin
            ACCESS_ERROR <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // memory access gate
    // ------------------------------------------------------------------
    logic blocked;

    assign blocked = secure_nxt && MEM_TO_SECURE
        && (!MEM_FROM_SECURE || MEM_FROM_DEBUG);

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            MEM_GRANT <= 1'b0;
            MEM_WR_OUT <= 1'b0;
            MEM_RDATA <= 8'h00;
        end
        else
        begin
            MEM_GRANT <= MEM_REQ && !blocked && !key_wr;
            MEM_WR_OUT <= MEM_REQ && MEM_WR && !blocked && !key_wr;
            MEM_RDATA <= blocked ? 8'h00 : MEM_RDATA_IN;
        end
    end

    // ------------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            SECURE <= 1'b1;
            DEBUG_EN_ALLOW <= 1'b0;
            BKGD_ENTRY <= 1'b0;
            PGM_ENABLE <= 1'b0;
            KEY_PROTECTED <= 1'b0;
        end
        else
        begin
            SECURE <= secure_nxt || !loaded_r;
            DEBUG_EN_ALLOW <= loaded_r && !secure_nxt;
            BKGD_ENTRY <= loaded_r && (!secure_nxt || bkgd_low_r);
            PGM_ENABLE <= clkdiv_r[CDIV_LOADED_BIT];
            KEY_PROTECTED <= !protect_r[0]
                && {protect_r[7:1], 9'h1FF} < VECTOR_BLOCK_BASE + 16'h1FF;
        end
    end

    // ------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            REG_RDATA <= 8'h00;
        end
        else if (REG_RD)
        begin
            unique case (REG_ADDR)
                ADDR_CLKDIV: REG_RDATA <= clkdiv_r;
                ADDR_OPTIONS: REG_RDATA <= options_r;
                ADDR_CONFIG: REG_RDATA <= config_r;
                ADDR_PROTECT: REG_RDATA <= protect_r;
                ADDR_STATUS: REG_RDATA <= {3'h0, bkgd_low_r,
                    !secure_nxt, clkdiv_r[CDIV_LOADED_BIT],
                    ACCESS_ERROR, secure_nxt};
                ADDR_KEYCAP: REG_RDATA <= key_seen_r;
                default: REG_RDATA <= 8'h00;
            endcase
        end
        else
        begin
            REG_RDATA <= 8'h00;
        end
    end

endmodule : fsc_top
